// File: rtl/uart_msr_pkg.sv
// shared constants for the modem status and baud configuration block
// assumes byte-wide register access with a small offset space
package uart_msr_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [4:0] OFF_DIV_LOW = 5'h00;
	localparam logic [4:0] OFF_DIV_HIGH = 5'h01;
	localparam logic [4:0] OFF_SAMPLE = 5'h02;
	localparam logic [4:0] OFF_LINE_CTRL = 5'h03;
	localparam logic [4:0] OFF_MODEM_CTRL = 5'h04;
	localparam logic [4:0] OFF_MODEM_STAT = 5'h06;
	localparam logic [4:0] OFF_SPECIAL = 5'h07;
	localparam logic [4:0] OFF_RX_COUNT = 5'h15;
	localparam logic [4:0] OFF_TX_COUNT = 5'h16;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LCR_DIV_ACCESS = 7;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	localparam int MCR_AUX_ONE = 2;
	localparam int MCR_AUX_TWO = 3;
	localparam int MCR_LOOPBACK = 4;
	localparam int SFR_FORCE_TX = 0;
	localparam int SFR_AUTO_DSR = 1;
	localparam int SFR_ENHANCED = 5;
	localparam int SFR_RX_SEL = 6;
	localparam int SFR_TX_SEL = 7;
	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] SFR_WR_MASK = 8'hF3;
	localparam logic [7:0] MCR_WR_MASK = 8'h1F;
	localparam logic [7:0] SAMPLE_WR_MASK = 8'h0F;
	// ----------------------------------------
	// oversampling decode
	// ----------------------------------------
	localparam logic [4:0] SC_BASE = 5'h10;
	localparam logic [3:0] SC_MAX_CODE = 4'hC;
endpackage

// File: rtl/baud_cfg_if.sv
// carrier between register file and baud rate generator
// assumes both ends share clk_i
`timescale 1ns/1ps
`default_nettype none
interface baud_cfg_if;
	logic [15:0] divisor;
	logic [3:0] sample_code;
	logic sample_tick;
	logic bit_tick;
	logic div_invalid;
	modport gen (input divisor, input sample_code, output sample_tick, output bit_tick,
		output div_invalid);
	modport user (output divisor, output sample_code, input sample_tick, input bit_tick,
		input div_invalid);
endinterface
`default_nettype wire

// File: rtl/modem_delta.sv
// one modem input: level history and sticky change flag
// assumes level_i is already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module modem_delta #(
	parameter bit RISE_ONLY = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	input wire logic clear_i,
	output logic level_o,
	output logic flag_o
);
	logic prev_q;
	logic flag_q;
	logic event_w;

	// a ring indicator only counts its low to high edge
	assign event_w = RISE_ONLY ? (level_i & ~prev_q) : (level_i ^ prev_q);

	// --------------------------------
	// history and flag
	// --------------------------------
	// set beats clear so a change during the read is kept
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			prev_q <= level_i;
			flag_q <= event_w | (flag_q & ~clear_i);
		end
	end

	assign level_o = prev_q;
	assign flag_o = flag_q;
endmodule
`default_nettype wire

// File: rtl/baud_gen.sv
// baud rate generator: divisor prescale then oversample count
// assumes settings change only while the line is idle
`timescale 1ns/1ps
`default_nettype none
module baud_gen
	import uart_msr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	baud_cfg_if.gen cfg
);
	logic [15:0] div_cnt_q;
	logic [4:0] smp_cnt_q;
	logic [4:0] smp_total_w;
	logic div_zero_w;
	logic div_wrap_w;
	logic smp_wrap_w;

	// --------------------------------
	// decode
	// --------------------------------
	// reserved codes fall back to sixteen samples
	assign smp_total_w = (cfg.sample_code > SC_MAX_CODE) ? SC_BASE
		: SC_BASE - {1'b0, cfg.sample_code};
	assign div_zero_w = (cfg.divisor == 16'h0000);
	assign div_wrap_w = ~div_zero_w & (div_cnt_q >= cfg.divisor - 16'h0001);
	assign smp_wrap_w = div_wrap_w & (smp_cnt_q >= smp_total_w - 5'h01);

	// --------------------------------
	// counters
	// --------------------------------
	// zero divisor stalls everything rather than ticking every cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_q <= 16'h0000;
			smp_cnt_q <= 5'h00;
		end else if (div_zero_w) begin
			div_cnt_q <= 16'h0000;
			smp_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= div_wrap_w ? 16'h0000 : div_cnt_q + 16'h0001;
			if (div_wrap_w) begin
				smp_cnt_q <= smp_wrap_w ? 5'h00 : smp_cnt_q + 5'h01;
			end
		end
	end

	assign cfg.sample_tick = div_wrap_w;
	assign cfg.bit_tick = smp_wrap_w;
	assign cfg.div_invalid = div_zero_w;
endmodule
`default_nettype wire

// File: rtl/uart_msr_baud.sv
// modem status capture, special functions and baud configuration of one channel
// assumes a byte register port and modem pins synchronous-capable to clk_i
`timescale 1ns/1ps
`default_nettype none
module uart_msr_baud (
	input wire logic clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic data_reg_access_o,
	// modem pins
	input wire logic cts_i,
	input wire logic dsr_i,
	input wire logic ri_i,
	input wire logic dcd_i,
	output logic dtr_n_o,
	output logic rts_n_o,
	// datapath side
	input wire logic [7:0] rx_fifo_fill_count_i,
	input wire logic [7:0] tx_fifo_fill_count_i,
	input wire logic [7:0] line_status_err_count_i,
	input wire logic tx_flow_hold_i,
	input wire logic rx_room_i,
	output logic tx_enable_o,
	output logic enhanced_mode_o,
	output logic sample_tick_o,
	output logic bit_tick_o,
	output logic divisor_invalid_o
);
	import uart_msr_pkg::*;

	// carrier to the baud generator; both ends run on clk_i
	baud_cfg_if cfg ();

	logic [7:0] div_low_q;
	logic [7:0] div_high_q;
	logic [7:0] sample_q;
	logic [7:0] line_control_reg_q;
	logic [7:0] modem_ctrl_q;
	logic [7:0] special_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] level_in_w;
	logic [3:0] level_w;
	logic [3:0] delta_w;
	logic hit_div_low_w;
	logic hit_div_high_w;
	logic hit_sample_w;
	logic hit_line_w;
	logic hit_modem_w;
	logic hit_status_w;
	logic hit_special_w;
	logic hit_tx_count_w;
	logic div_access_w;
	logic low_off_w;
	logic wr_div_low_w;
	logic wr_div_high_w;
	logic wr_sample_w;
	logic wr_line_w;
	logic wr_modem_w;
	logic wr_special_w;
	logic msr_read_w;
	logic loopback_w;
	logic [7:0] modem_status_w;
	logic [7:0] count15_w;
	logic [7:0] count16_w;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// offset map as the host sees it, steering bit clear / set:
	// 00h data path / divisor low byte
	// 01h data path / divisor high byte
	// 02h data path / sample code, bits 7:4 read zero
	// 03h line control, only bit 7 acts inside this block
	// 04h modem control: dtr, rts, aux one, aux two, loopback
	// 05h line status lives in the data path and reads zero here
	// 06h modem status: change flags low, live levels high
	// 07h special functions: force, auto dsr/dtr, mode, selects
	// 15h error count or rx fill count, read only
	// 16h tx fill count or the sample code again
	// every other offset reads zero and ignores writes
	//
	// one named hit per offset except 15h, so the write and read decodes agree
	assign hit_div_low_w = (reg_addr_i == OFF_DIV_LOW);
	assign hit_div_high_w = (reg_addr_i == OFF_DIV_HIGH);
	assign hit_sample_w = (reg_addr_i == OFF_SAMPLE);
	assign hit_line_w = (reg_addr_i == OFF_LINE_CTRL);
	assign hit_modem_w = (reg_addr_i == OFF_MODEM_CTRL);
	assign hit_status_w = (reg_addr_i == OFF_MODEM_STAT);
	assign hit_special_w = (reg_addr_i == OFF_SPECIAL);
	assign hit_tx_count_w = (reg_addr_i == OFF_TX_COUNT);

	// divisor access bit decides who owns offsets 00h to 02h
	assign div_access_w = line_control_reg_q[LCR_DIV_ACCESS];
	assign low_off_w = hit_div_low_w | hit_div_high_w | hit_sample_w;
	// the data path still sees its own cycles; this block only flags them
	assign data_reg_access_o = low_off_w & ~div_access_w & (reg_wr_i | reg_rd_i);
	assign wr_div_low_w = reg_wr_i & div_access_w & hit_div_low_w;
	assign wr_div_high_w = reg_wr_i & div_access_w & hit_div_high_w;
	// sample code also reachable at 16h when that offset is not the tx count
	assign wr_sample_w = reg_wr_i & ((div_access_w & hit_sample_w)
		| (~special_q[SFR_TX_SEL] & hit_tx_count_w));
	assign wr_line_w = reg_wr_i & hit_line_w;
	assign wr_modem_w = reg_wr_i & hit_modem_w;
	assign wr_special_w = reg_wr_i & hit_special_w;
	// a read clears the flags even when the host discards its data
	assign msr_read_w = reg_rd_i & hit_status_w;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// reserved bits are masked on the way in, so reads need no extra logic
	// a write and a read in one cycle: the read sees the old value
	// line control keeps all eight bits for the data path; only bit 7 acts here
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_low_q <= RST_BYTE;
			div_high_q <= RST_BYTE;
			sample_q <= RST_BYTE;
			line_control_reg_q <= RST_BYTE;
			modem_ctrl_q <= RST_BYTE;
			special_q <= RST_BYTE;
		end else begin
			if (wr_div_low_w) begin
				div_low_q <= reg_wdata_i;
			end
			if (wr_div_high_w) begin
				div_high_q <= reg_wdata_i;
			end
			if (wr_sample_w) begin
				sample_q <= reg_wdata_i & SAMPLE_WR_MASK;
			end
			if (wr_line_w) begin
				line_control_reg_q <= reg_wdata_i;
			end
			if (wr_modem_w) begin
				modem_ctrl_q <= reg_wdata_i & MCR_WR_MASK;
			end
			if (wr_special_w) begin
				special_q <= reg_wdata_i & SFR_WR_MASK;
			end
		end
	end

	// ----------------------------------------
	// modem input capture
	// ----------------------------------------
	// order in all 4-bit vectors: cts, dsr, ri, dcd
	// two flops before any edge logic so one pin edge makes one event
	// cost: a pin change reaches the status byte three cycles later
	// reset to zero: a line already high at release reports one change
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= {dcd_i, ri_i, dsr_i, cts_i};
			sync2_q <= sync1_q;
		end
	end

	// loopback swaps ri and dcd for the auxiliary outputs
	// cts and dsr stay on their pins in loopback
	assign loopback_w = modem_ctrl_q[MCR_LOOPBACK];
	assign level_in_w = {loopback_w ? modem_ctrl_q[MCR_AUX_TWO] : sync2_q[3],
		loopback_w ? modem_ctrl_q[MCR_AUX_ONE] : sync2_q[2],
		sync2_q[1], sync2_q[0]};

	// one tracker per line; only ri counts rising edges alone
	// the parameter picks the edge kind; set beats the read clear inside
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_line
			if (g == 2) begin : g_rise
				modem_delta #(.RISE_ONLY(1'b1)) u_delta (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.level_i(level_in_w[g]),
					.clear_i(msr_read_w),
					.level_o(level_w[g]),
					.flag_o(delta_w[g])
				);
			end else begin : g_any
				modem_delta #(.RISE_ONLY(1'b0)) u_delta (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.level_i(level_in_w[g]),
					.clear_i(msr_read_w),
					.level_o(level_w[g]),
					.flag_o(delta_w[g])
				);
			end
		end
	endgenerate

	// status byte: flags in 3:0, live levels in 7:4, in the order
	// cts, dsr, ri, dcd from the low bit up; levels come from the history
	// flop, so a flag and its level always describe the same sample
	assign modem_status_w = {level_w, delta_w};

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// both counters are plain pass-throughs; the data path owns them
	assign count15_w = special_q[SFR_RX_SEL] ? line_status_err_count_i
		: rx_fifo_fill_count_i;
	assign count16_w = special_q[SFR_TX_SEL] ? tx_fifo_fill_count_i : sample_q;

	// low offsets read zero when the data path owns them
	// unmapped offsets fall to the default branch and read zero
	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr_i)
			OFF_DIV_LOW: rdata_d = div_access_w ? div_low_q : 8'h00;
			OFF_DIV_HIGH: rdata_d = div_access_w ? div_high_q : 8'h00;
			OFF_SAMPLE: rdata_d = div_access_w ? sample_q : 8'h00;
			OFF_LINE_CTRL: rdata_d = line_control_reg_q;
			OFF_MODEM_CTRL: rdata_d = modem_ctrl_q;
			OFF_MODEM_STAT: rdata_d = modem_status_w;
			OFF_SPECIAL: rdata_d = special_q;
			OFF_RX_COUNT: rdata_d = count15_w;
			OFF_TX_COUNT: rdata_d = count16_w;
			default: rdata_d = 8'h00;
		endcase
	end

	// read data lands one cycle after the read strobe
	// held between reads so a slow host can pick it up later
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ----------------------------------------
	// baud generator
	// ----------------------------------------
	// divisor and code feed the counters directly; a change mid-frame
	// stretches or cuts one bit, so software should change them while idle
	// a zero divisor is flagged rather than ticking every clock
	assign cfg.divisor = {div_high_q, div_low_q};
	assign cfg.sample_code = sample_q[3:0];

	baud_gen u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cfg(cfg)
	);

	assign sample_tick_o = cfg.sample_tick;
	assign bit_tick_o = cfg.bit_tick;
	assign divisor_invalid_o = cfg.div_invalid;

	// ----------------------------------------
	// flow control and mode outputs
	// ----------------------------------------
	// force overrides every hold; auto mode also waits for dsr
	// force wins even over auto dsr, so a silent peer cannot stall the line
	assign tx_enable_o = special_q[SFR_FORCE_TX]
		| (~tx_flow_hold_i & (~special_q[SFR_AUTO_DSR] | level_w[1]));
	// auto mode drops dtr when the receiver has no room
	// no hysteresis on rx_room_i: dtr follows every change of it
	assign dtr_n_o = special_q[SFR_AUTO_DSR] ? ~rx_room_i
		: ~modem_ctrl_q[MCR_DTR];
	assign rts_n_o = ~modem_ctrl_q[MCR_RTS];
	// mode bit only leaves the block; the data path acts on it
	assign enhanced_mode_o = special_q[SFR_ENHANCED];
endmodule
`default_nettype wire

// File: testbench/uart_msr_baud_chk.sv
// assertions on the ports of the modem status and baud configuration block
// assumes one clock domain and the byte register port of the top module
`timescale 1ns/1ps
`default_nettype none
module uart_msr_baud_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic data_reg_access_o,
	input wire logic cts_i,
	input wire logic dtr_n_o,
	input wire logic [7:0] rx_fifo_fill_count_i,
	input wire logic [7:0] tx_fifo_fill_count_i,
	input wire logic [7:0] line_status_err_count_i,
	input wire logic tx_flow_hold_i,
	input wire logic rx_room_i,
	input wire logic tx_enable_o,
	input wire logic enhanced_mode_o,
	input wire logic sample_tick_o,
	input wire logic bit_tick_o,
	input wire logic divisor_invalid_o
);
	logic lcr7_q;
	logic [7:0] sfr_q;
	wire logic [7:0] cnt15 = sfr_q[6] ? line_status_err_count_i : rx_fifo_fill_count_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// shadow of the steering and special bits
	// ----------------------------------------
	// shadow kept here so checks do not lean on hidden state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lcr7_q <= 1'b0;
			sfr_q <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 5'h03) lcr7_q <= reg_wdata_i[7];
			if (reg_addr_i == 5'h07) sfr_q <= reg_wdata_i;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_cts_level_shown: assert property (reg_rd_i && reg_addr_i == 5'h06 && !$past(rst_i, 3)
		&& cts_i == $past(cts_i) && cts_i == $past(cts_i, 2) && cts_i == $past(cts_i, 3)
		|=> reg_rdata_o[4] == $past(cts_i)) else $error("cts level bit wrong");
	a_force_tx_on: assert property (sfr_q[0] |-> tx_enable_o) else $error("force tx ignored");
	a_hold_blocks_tx: assert property (!sfr_q[0] && tx_flow_hold_i |-> !tx_enable_o)
		else $error("tx not held");
	a_auto_dtr_room: assert property (sfr_q[1] |-> dtr_n_o == !rx_room_i)
		else $error("auto dtr wrong");
	a_enh_mode_bit: assert property (enhanced_mode_o == sfr_q[5]) else $error("mode bit wrong");
	a_rx_count_sel: assert property (reg_rd_i && reg_addr_i == 5'h15
		|=> reg_rdata_o == $past(cnt15)) else $error("15h select wrong");
	a_tx_count_sel: assert property (reg_rd_i && reg_addr_i == 5'h16 && sfr_q[7]
		|=> reg_rdata_o == $past(tx_fifo_fill_count_i)) else $error("16h select wrong");
	a_sample_upper_zero: assert property (reg_rd_i && reg_addr_i == 5'h02 && lcr7_q
		|=> reg_rdata_o[7:4] == 4'h0) else $error("sample upper bits set");
	a_low_offset_steer: assert property (data_reg_access_o ==
		((reg_rd_i || reg_wr_i) && reg_addr_i <= 5'h02 && !lcr7_q)) else $error("steer wrong");
	a_no_tick_invalid: assert property (divisor_invalid_o |-> !sample_tick_o && !bit_tick_o)
		else $error("tick on zero divisor");
	a_bit_on_sample: assert property (bit_tick_o |-> sample_tick_o)
		else $error("bit tick off sample");
endmodule
bind uart_msr_baud uart_msr_baud_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .data_reg_access_o(data_reg_access_o),
	.cts_i(cts_i), .dtr_n_o(dtr_n_o), .rx_fifo_fill_count_i(rx_fifo_fill_count_i),
	.tx_fifo_fill_count_i(tx_fifo_fill_count_i), .line_status_err_count_i(line_status_err_count_i),
	.tx_flow_hold_i(tx_flow_hold_i), .rx_room_i(rx_room_i), .tx_enable_o(tx_enable_o),
	.enhanced_mode_o(enhanced_mode_o), .sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o),
	.divisor_invalid_o(divisor_invalid_o));
`default_nettype wire

// File: testbench/modem_peer.sv
// behavioural modem peer driving the four status lines
// assumes the bench sets the wanted levels just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module modem_peer (
	input wire logic clk_i,
	input wire logic [3:0] lv_i,
	output logic [3:0] pins_o
);
	// lines change just after an edge, like a slow external part
	initial pins_o = 4'h0;
	// levels are taken at the edge, so the bench may change them between edges
	always @(posedge clk_i) begin
		pins_o <= #1 lv_i;
	end
endmodule
`default_nettype wire

// File: testbench/uart_msr_baud_test.sv
// self-checking bench for the modem status and baud configuration block
// assumes the peer model drives cts, dsr, ri and dcd
`timescale 1ns/1ps
`default_nettype none
module uart_msr_baud_test;
	logic clk_i, rst_i, reg_wr_i, reg_rd_i, tx_flow_hold_i, rx_room_i;
	logic [4:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic [3:0] lv;
	wire logic [3:0] pins;
	wire logic [7:0] reg_rdata_o;
	wire logic dra, dtr_n_o, rts_n_o, tx_enable_o, enhanced_mode_o, st, bit_tick_o, dinv;
	int n_errors = 0;
	int samples_checked = 0;
	uart_msr_baud i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .data_reg_access_o(dra), .cts_i(pins[0]), .dsr_i(pins[1]),
		.ri_i(pins[2]), .dcd_i(pins[3]), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
		.rx_fifo_fill_count_i(8'h11), .tx_fifo_fill_count_i(8'h22),
		.line_status_err_count_i(8'h33), .tx_flow_hold_i(tx_flow_hold_i), .rx_room_i(rx_room_i),
		.tx_enable_o(tx_enable_o), .enhanced_mode_o(enhanced_mode_o), .sample_tick_o(st),
		.bit_tick_o(bit_tick_o), .divisor_invalid_o(dinv));
	modem_peer i_peer (.clk_i(clk_i), .lv_i(lv), .pins_o(pins));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(posedge clk_i);
		#1;
		reg_wr_i = 1'b0;
	endtask
	// data is registered on the taking edge, so it is read one step later
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk_i);
		#1;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(posedge clk_i);
		#1;
		reg_rd_i = 1'b0;
		chk(reg_rdata_o, e);
	endtask
	// first interval may be ragged after a change, so the third is timed
	task automatic per(input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clk_i);
				#1 n++;
			end while (bit_tick_o !== 1'b1 && n < 100);
		end
		chk(n, e);
	endtask
	// ----------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#100000 n_errors++;
		wrap_up();
	end
	initial begin
		{rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, lv} = {1'b1, 19'h0};
		{tx_flow_hold_i, rx_room_i} = 2'b00;
		repeat (6) @(posedge clk_i);
		#1 rst_i = 1'b0;
		chk(dinv, 1'b1);
		wr(5'h03, 8'h80);
		rd(5'h00, 8'h00);
		rd(5'h01, 8'h00);
		rd(5'h06, 8'h00);
		wr(5'h00, 8'hA5);
		wr(5'h01, 8'h3C);
		wr(5'h02, 8'hFF);
		rd(5'h00, 8'hA5);
		rd(5'h01, 8'h3C);
		rd(5'h02, 8'h0F);
		wr(5'h03, 8'h00);
		wr(5'h00, 8'h55);
		rd(5'h00, 8'h00);
		wr(5'h03, 8'h80);
		rd(5'h00, 8'hA5);
		wr(5'h00, 8'h02);
		wr(5'h01, 8'h00);
		for (int c = 0; c <= 12; c++) begin
			wr(5'h02, 8'(c));
			per((16 - c) * 2);
		end
		wr(5'h03, 8'h00);
		lv = 4'hF;
		repeat (4) @(posedge clk_i);
		rd(5'h06, 8'hFF);
		rd(5'h06, 8'hF0);
		lv = 4'h0;
		repeat (4) @(posedge clk_i);
		rd(5'h06, 8'h0B);
		wr(5'h04, 8'h1F);
		chk({dtr_n_o, rts_n_o}, 2'b00);
		repeat (4) @(posedge clk_i);
		rd(5'h06, 8'hCC);
		wr(5'h04, 8'h00);
		chk({dtr_n_o, rts_n_o}, 2'b11);
		repeat (4) @(posedge clk_i);
		rd(5'h06, 8'h08);
		// cts change lands on the very edge that takes the clearing read
		lv = 4'h1;
		repeat (2) @(posedge clk_i);
		rd(5'h06, 8'h00);
		rd(5'h06, 8'h11);
		wr(5'h07, 8'h40);
		rd(5'h15, 8'h33);
		wr(5'h07, 8'h00);
		rd(5'h15, 8'h11);
		rd(5'h16, 8'h0C);
		wr(5'h07, 8'h80);
		rd(5'h16, 8'h22);
		wr(5'h07, 8'h20);
		chk(enhanced_mode_o, 1'b1);
		tx_flow_hold_i = 1'b1;
		wr(5'h07, 8'h01);
		chk(tx_enable_o, 1'b1);
		wr(5'h07, 8'h02);
		chk(tx_enable_o, 1'b0);
		tx_flow_hold_i = 1'b0;
		rx_room_i = 1'b1;
		#1 chk(tx_enable_o, 1'b0);
		chk(dtr_n_o, 1'b0);
		lv = 4'h2;
		repeat (5) @(posedge clk_i);
		#1 chk(tx_enable_o, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
